// ===== scad_consts.svh
// timing, width and encoding constants for the command and address front end
`ifndef SCAD_CONSTS_SVH
`define SCAD_CONSTS_SVH
`define SCAD_BANKS        4
`define SCAD_BANK_W       2
`define SCAD_ADDR_W       14
`define SCAD_COL_W        10
`define SCAD_AP_BIT       10
`define SCAD_TOP_ROW_BIT  13
`define SCAD_DQ_W         8
`define SCAD_STORE_AW     6
`define SCAD_BURST_LAST   2'h3
`define SCAD_EMR_BANK     2'h1
`define SCAD_DQS_DIS_BIT  10
`define SCAD_SYS_CLK_MHZ  200
`define SCAD_LINK_CLK_NS  48
`endif

// ===== scad_pkg.sv
// shared types of the command and address front end
`include "scad_consts.svh"
package scad_pkg;
  typedef enum logic [2:0] {
    CMD_NONE,
    CMD_ACT,
    CMD_PRE,
    CMD_RD,
    CMD_WR,
    CMD_MRS
  } scad_cmd_t;

  typedef enum logic [1:0] {
    BURST_IDLE,
    BURST_RD,
    BURST_WR
  } scad_burst_t;

  typedef struct packed {
    scad_cmd_t                      kind;
    logic [`SCAD_BANK_W-1:0]        bank;
    logic [`SCAD_ADDR_W-1:0]        row;
    logic [`SCAD_COL_W-1:0]         col;
    logic                           auto_pre;
  } scad_rec_t;
endpackage

// ===== scad_mem_if.sv
// carrier between the decoder and its byte store
`include "scad_consts.svh"
interface scad_mem_if;
  logic                         we;
  logic [`SCAD_STORE_AW-1:0]    waddr;
  logic [`SCAD_DQ_W-1:0]        wdata;
  logic [`SCAD_STORE_AW-1:0]    raddr;
  logic [`SCAD_DQ_W-1:0]        rdata;
  modport ctl (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

// ===== scad_byte_store.sv
// small byte store with registered read data, link clock domain
`include "scad_consts.svh"
module scad_byte_store (
  input  wire logic   i_clk,    // link clock
  input  wire logic   i_rst_n,  // link reset, active low
  scad_mem_if.mem     mem       // store port
);
  logic [`SCAD_DQ_W-1:0] store [0:(1<<`SCAD_STORE_AW)-1];
  logic [`SCAD_DQ_W-1:0] rdata_q;

  always_ff @(posedge i_clk) begin
    if (mem.we) begin
      store[mem.waddr] <= mem.wdata;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= store[mem.raddr];
    end
  end

  assign mem.rdata = rdata_q;
endmodule

// ===== scad_decode.sv
// command and address decode of the sdram front end, with read and write burst data path
//
// Contract
// - command acts only on the bank named by bank select inputs, except precharge with the flag line high, which closes every bank.
// - activate captures fourteen-bit address as row of addressed bank, top bit gated by the organisation strap.
// - read/write takes low ten lines as column, flag line as auto precharge.
// - top row address bit used for row only in byte-wide organisation.
// - chip select low enables decoder; high masks every command.
// - control lines latched at rising true clock; controller holds them valid.
// - cs, ras low, cas high: write select high activates, low precharges.
// - precharge closes selected bank; activate opens selected bank.
// - cs low, ras high, cas low starts a column access.
// - column access reads with write select high, writes with it low.
// - device drives strobe for reads, controller drives it for writes.
// - read strobe edges aligned with data; write strobe centred by controller.
// - complementary strobe used only when enabled by mode register load.
// - clock gating low suspends next cycle, freezing outputs and burst state.
// - write beats sampled with mask high leave the store unchanged.
`include "scad_consts.svh"
module scad_decode (
  input  wire logic                            i_sys_clk,        // system clock, 200 MHz
  input  wire logic                            i_rst_n,          // async reset, active low
  input  wire logic                            i_ck,             // true memory clock from controller
  input  wire logic                            i_cke,            // clock gating
  input  wire logic                            i_cs_n,           // chip select, active low
  input  wire logic                            i_ras_n,          // row strobe, active low
  input  wire logic                            i_cas_n,          // column strobe, active low
  input  wire logic                            i_we_n,           // write select, active low
  input  wire logic [`SCAD_BANK_W-1:0]         i_bank_select_inputs,     // bank select
  input  wire logic [`SCAD_ADDR_W-1:0]         i_multiplexed_address_bus, // row/column address
  input  wire logic                            i_data_mask_input, // write byte mask
  input  wire logic [`SCAD_DQ_W-1:0]           i_dq,             // write data
  input  wire logic                            i_byte_wide_org,  // organisation strap, high = x8
  output logic [`SCAD_DQ_W-1:0]                o_dq,             // read data
  output logic                                 o_dq_oe_n,        // read data enable, low drives
  output logic                                 o_dqs,            // read strobe
  output logic                                 o_dqs_oe_n,       // strobe enable, low drives
  output logic                                 o_dqs_c,          // complementary strobe
  output logic                                 o_dqs_c_oe_n,     // complementary enable, low drives
  output logic                                 o_cmd_valid,      // one-cycle pulse per command
  output scad_pkg::scad_cmd_t                  o_cmd_kind,       // decoded command
  output logic [`SCAD_BANK_W-1:0]              o_cmd_bank,       // addressed bank
  output logic [`SCAD_ADDR_W-1:0]              o_cmd_row,        // row of command
  output logic [`SCAD_COL_W-1:0]               o_cmd_col,        // column of access
  output logic                                 o_cmd_auto_pre    // auto precharge request
);
  import scad_pkg::*;

  function automatic scad_cmd_t decode_cmd(
    input logic cs_n,
    input logic ras_n,
    input logic cas_n,
    input logic we_n
  );
    scad_cmd_t c;
    c = CMD_NONE;
    if (!cs_n) begin
      case ({ras_n, cas_n, we_n})
        3'b011:  c = CMD_ACT;
        3'b010:  c = CMD_PRE;
        3'b101:  c = CMD_RD;
        3'b100:  c = CMD_WR;
        3'b000:  c = CMD_MRS;
        default: c = CMD_NONE;
      endcase
    end
    return c;
  endfunction

  // link reset: asserted asynchronously, released on the link clock
  logic rl1_q;
  logic rl2_q;
  logic rst_link_n;

  always_ff @(posedge i_ck or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rl1_q <= 1'b0;
      rl2_q <= 1'b0;
    end else begin
      rl1_q <= 1'b1;
      rl2_q <= rl1_q;
    end
  end
  assign rst_link_n = rl2_q;

  // strap is a static pin, still synchronised before use
  logic org1_q;
  logic org2_q;

  always_ff @(posedge i_ck or negedge rst_link_n) begin
    if (!rst_link_n) begin
      org1_q <= 1'b0;
      org2_q <= 1'b0;
    end else begin
      org1_q <= i_byte_wide_org;
      org2_q <= org1_q;
    end
  end

  // clock gating as seen one edge earlier
  logic cke_q;

  always_ff @(posedge i_ck or negedge rst_link_n) begin
    if (!rst_link_n) begin
      cke_q <= 1'b0;
    end else begin
      cke_q <= i_cke;
    end
  end

  scad_cmd_t                 cmd;
  logic [`SCAD_BANK_W-1:0]   bank;
  logic [`SCAD_ADDR_W-1:0]   row_in;
  logic                      ap_in;

  // control lines used as sampled on the rising true clock
  assign cmd    = (cke_q && i_cke) ? decode_cmd(i_cs_n, i_ras_n, i_cas_n, i_we_n) : CMD_NONE;
  assign bank   = i_bank_select_inputs;
  assign row_in = {i_multiplexed_address_bus[`SCAD_TOP_ROW_BIT] & org2_q,
                   i_multiplexed_address_bus[`SCAD_TOP_ROW_BIT-1:0]};
  assign ap_in  = i_multiplexed_address_bus[`SCAD_AP_BIT];

  // burst state
  scad_burst_t               bst_q;
  logic [1:0]                beat_q;
  logic [`SCAD_BANK_W-1:0]   bbank_q;
  logic [`SCAD_COL_W-1:0]    bcol_q;
  logic                      bap_q;
  logic                      bend;

  // a gated cycle never counts as the last beat
  assign bend = (bst_q != BURST_IDLE) && cke_q && (beat_q == `SCAD_BURST_LAST);

  always_ff @(posedge i_ck or negedge rst_link_n) begin
    if (!rst_link_n) begin
      bst_q   <= BURST_IDLE;
      beat_q  <= 2'h0;
      bbank_q <= 2'h0;
      bcol_q  <= 10'h000;
      bap_q   <= 1'b0;
    end else if (cmd == CMD_RD || cmd == CMD_WR) begin
      // a new access cuts any running burst short
      bst_q   <= (cmd == CMD_RD) ? BURST_RD : BURST_WR;
      beat_q  <= 2'h0;
      bbank_q <= bank;
      bcol_q  <= i_multiplexed_address_bus[`SCAD_COL_W-1:0];
      bap_q   <= ap_in;
    end else if (cke_q) begin
      if (bend) begin
        bst_q <= BURST_IDLE;
      end
      if (bst_q != BURST_IDLE) begin
        beat_q <= beat_q + 2'h1;
      end
    end
  end

  // bank open flags and row store
  logic [`SCAD_BANKS-1:0]    act_q;
  logic [`SCAD_ADDR_W-1:0]   row_q [`SCAD_BANKS];
  logic                      dstrb_q;

  always_ff @(posedge i_ck or negedge rst_link_n) begin
    if (!rst_link_n) begin
      act_q <= 4'h0;
    end else begin
      for (int b = 0; b < `SCAD_BANKS; b++) begin
        // an activate in the cycle a burst closes the bank wins
        if (cmd == CMD_ACT && bank == b[`SCAD_BANK_W-1:0]) begin
          act_q[b] <= 1'b1;
        end else if (cmd == CMD_PRE && (ap_in || bank == b[`SCAD_BANK_W-1:0])) begin
          act_q[b] <= 1'b0;
        end else if (bend && bap_q && bbank_q == b[`SCAD_BANK_W-1:0]) begin
          act_q[b] <= 1'b0;
        end
      end
    end
  end

  generate
    for (genvar g = 0; g < `SCAD_BANKS; g++) begin : g_row
      always_ff @(posedge i_ck or negedge rst_link_n) begin
        if (!rst_link_n) begin
          row_q[g] <= 14'h0000;
        end else if (cmd == CMD_ACT && bank == (`SCAD_BANK_W)'(g)) begin
          row_q[g] <= row_in;
        end
      end
    end
  endgenerate

  always_ff @(posedge i_ck or negedge rst_link_n) begin
    if (!rst_link_n) begin
      dstrb_q <= 1'b0;
    end else if (cmd == CMD_MRS && bank == `SCAD_EMR_BANK) begin
      dstrb_q <= !i_multiplexed_address_bus[`SCAD_DQS_DIS_BIT];
    end
  end

  // byte store
  scad_mem_if mem_if ();
  logic [1:0] bidx;

  assign bidx         = bcol_q[1:0] + beat_q;
  assign mem_if.raddr = {bbank_q, bcol_q[3:2], bidx};
  assign mem_if.waddr = {bbank_q, bcol_q[3:2], bidx};
  assign mem_if.wdata = i_dq;
  assign mem_if.we    = (bst_q == BURST_WR) && cke_q && !i_data_mask_input;

  scad_byte_store u_store (
    .i_clk   (i_ck),
    .i_rst_n (rst_link_n),
    .mem     (mem_if.mem)
  );

  // read return: data and strobe launched by the same edge
  logic rv_q;

  always_ff @(posedge i_ck or negedge rst_link_n) begin
    if (!rst_link_n) begin
      rv_q <= 1'b0;
    end else if (cke_q) begin
      rv_q <= (bst_q == BURST_RD);
    end
  end

  always_ff @(posedge i_ck or negedge rst_link_n) begin
    if (!rst_link_n) begin
      o_dq         <= 8'h00;
      o_dq_oe_n    <= 1'b1;
      o_dqs        <= 1'b0;
      o_dqs_oe_n   <= 1'b1;
      o_dqs_c      <= 1'b1;
      o_dqs_c_oe_n <= 1'b1;
    end else if (cke_q) begin
      o_dq         <= rv_q ? mem_if.rdata : 8'h00;
      o_dq_oe_n    <= !rv_q;
      o_dqs        <= rv_q ? !o_dqs : 1'b0;
      o_dqs_oe_n   <= !rv_q;
      o_dqs_c      <= rv_q ? o_dqs : 1'b1;
      o_dqs_c_oe_n <= !(rv_q && dstrb_q);
    end
  end

  // command record to the system domain, held until the next command
  scad_rec_t rec_q;
  logic      tgl_q;

  always_ff @(posedge i_ck or negedge rst_link_n) begin
    if (!rst_link_n) begin
      rec_q <= '0;
      tgl_q <= 1'b0;
    end else if (cmd != CMD_NONE) begin
      rec_q.kind     <= cmd;
      rec_q.bank     <= bank;
      rec_q.row      <= (cmd == CMD_ACT) ? row_in : row_q[bank];
      rec_q.col      <= i_multiplexed_address_bus[`SCAD_COL_W-1:0];
      rec_q.auto_pre <= (cmd == CMD_RD || cmd == CMD_WR) && ap_in;
      tgl_q          <= !tgl_q;
    end
  end

  // toggle crossing; record is stable well before the toggle is seen
  logic s1_q;
  logic s2_q;
  logic s3_q;

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= tgl_q;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_cmd_valid    <= 1'b0;
      o_cmd_kind     <= CMD_NONE;
      o_cmd_bank     <= 2'h0;
      o_cmd_row      <= 14'h0000;
      o_cmd_col      <= 10'h000;
      o_cmd_auto_pre <= 1'b0;
    end else begin
      o_cmd_valid <= s2_q ^ s3_q;
      if (s2_q ^ s3_q) begin
        o_cmd_kind     <= rec_q.kind;
        o_cmd_bank     <= rec_q.bank;
        o_cmd_row      <= rec_q.row;
        o_cmd_col      <= rec_q.col;
        o_cmd_auto_pre <= rec_q.auto_pre;
      end
    end
  end

  // checks on the link domain
  default clocking cb @(posedge i_ck); endclocking
  default disable iff (!rst_link_n);

  sequence rd_go;
    (cmd == CMD_RD) ##1 i_cke [*2];
  endsequence

  sequence act_go;
    cmd == CMD_ACT;
  endsequence

  AST_DESELECT_MASKED: assert property (i_cs_n |=> $stable(tgl_q))
    else $error("command taken with chip select high");
  AST_ACT_OPENS: assert property (act_go |=> act_q[$past(bank)])
    else $error("activate did not open bank");
  AST_PRE_CLOSES: assert property (cmd == CMD_PRE && !ap_in |=> !act_q[$past(bank)])
    else $error("precharge did not close bank");
  AST_PRE_ALL: assert property (cmd == CMD_PRE && ap_in |=> act_q == '0)
    else $error("all-bank precharge left a bank open");
  AST_AP_CLOSE: assert property (bend && bap_q && !(cmd == CMD_ACT && bank == bbank_q) |=> !act_q[$past(bbank_q)])
    else $error("auto precharge did not close bank at burst end");
  AST_ROW_CAPT: assert property (act_go |=> row_q[$past(bank)] == $past(row_in))
    else $error("row not captured");
  AST_TOP_ROW: assert property ((act_go and !org2_q) |=> row_q[$past(bank)][`SCAD_TOP_ROW_BIT] == 1'b0)
    else $error("top row bit used outside byte-wide");
  AST_NOP_KEEP: assert property (cmd == CMD_NONE && !i_cs_n && bst_q == BURST_IDLE |=> $stable(act_q))
    else $error("no-op changed bank state");
  AST_COL_BANK: assert property (cmd == CMD_WR |=> bcol_q == $past(i_multiplexed_address_bus[9:0])
                                 && bbank_q == $past(bank) && bap_q == $past(ap_in))
    else $error("column access captured wrong address");
  AST_RD_DRIVES: assert property (rd_go |=> !o_dq_oe_n && !o_dqs_oe_n)
    else $error("read data not driven");
  AST_STROBE_ALIGN: assert property (!o_dqs_oe_n && $past(cke_q) && $past(!o_dqs_oe_n) |-> $changed(o_dqs))
    else $error("read strobe did not toggle with data");
  AST_DIFF_OFF: assert property (!dstrb_q |=> o_dqs_c_oe_n)
    else $error("complementary strobe driven while disabled");
  AST_FREEZE: assert property (!cke_q && cmd == CMD_NONE |=> $stable(beat_q) && $stable(o_dq))
    else $error("state moved while clock gated");
  AST_MASK: assert property (bst_q == BURST_WR && i_data_mask_input |-> !mem_if.we)
    else $error("masked beat written");
endmodule

// ===== scad_ctrl_model.sv
// controller-side model: free running link clock, command lines and write data
`include "scad_consts.svh"
module scad_ctrl_model (
  output logic                     o_ck,    // link clock
  output logic                     o_cke,   // clock gating
  output logic                     o_cs_n,  // chip select
  output logic                     o_ras_n, // row strobe
  output logic                     o_cas_n, // column strobe
  output logic                     o_we_n,  // write select
  output logic [`SCAD_BANK_W-1:0]  o_bank,  // bank select
  output logic [`SCAD_ADDR_W-1:0]  o_addr,  // address bus
  output logic                     o_dm,    // write mask
  output logic [`SCAD_DQ_W-1:0]    o_dq     // write data
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    {o_ck, o_cke, o_cs_n, o_ras_n, o_cas_n, o_we_n} = 6'h3e;
    {o_bank, o_addr, o_dm, o_dq} = '0;
  end
  always #24 o_ck = ~o_ck;
  // lines change at the falling edge, so they sit still across the sampling rise
  task automatic cmd(input logic [3:0] ctl, input logic [1:0] bank, input logic [13:0] addr);
    @(negedge o_ck);
    {o_cs_n, o_ras_n, o_cas_n, o_we_n, o_bank, o_addr} = {ctl, bank, addr};
    @(negedge o_ck);
    // released: chip select goes high, the other lines show the inverse, never the stale value
    {o_cs_n, o_ras_n, o_cas_n, o_we_n, o_bank, o_addr} = {1'h1, ~{ctl[2:0], bank, addr}};
  endtask
  // one beat per link cycle, launched mid cycle so the rise lands in the centre
  task automatic wr_beats(input logic [31:0] data, input logic [3:0] mask);
    for (int k = 0; k < 4; k++) begin
      {o_dq, o_dm} = {data[8*k +: 8], mask[k]};
      @(negedge o_ck);
    end
    {o_dq, o_dm} = {~o_dq, 1'h0};
  endtask
  task automatic set_cke(input logic v);
    o_cke = v;
  endtask
endmodule

// ===== scad_decode_bench.sv
// self-checking bench of the command and address decode
`include "scad_consts.svh"
module scad_decode_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import scad_pkg::*;
  typedef struct packed {
    logic [3:0]  ctl;
    logic [1:0]  bank;
    logic [13:0] addr;
    logic        fires;
    scad_cmd_t   kind;
    logic [13:0] row;
  } scad_row_t;
  logic        sys_clk = 1'h0;
  logic        rst_n = 1'h0;
  logic        byte_wide = 1'h1;
  logic        ck, cke, cs_n, ras_n, cas_n, we_n, dm;
  logic [1:0]  bank;
  logic [13:0] addr;
  logic [7:0]  dq_in, dq_out;
  logic        dq_oe_n, dqs, dqs_oe_n, dqs_c, dqs_c_oe_n, cmd_valid, cmd_ap;
  scad_cmd_t   cmd_kind;
  logic [1:0]  cmd_bank;
  logic [13:0] cmd_row;
  logic [9:0]  cmd_col;
  logic [7:0]  shadow [64];
  int          mismatches = 0;
  int          checks = 0;
  int          pulses = 0;
  int          n0;
  scad_row_t   rows [0:7] = '{
    '{4'h3, 2'h0, 14'h2abc, 1'h1, CMD_ACT, 14'h2abc},
    '{4'h3, 2'h3, 14'h3001, 1'h1, CMD_ACT, 14'h3001},
    '{4'h5, 2'h0, 14'h0405, 1'h1, CMD_RD, 14'h2abc},
    '{4'h4, 2'h3, 14'h0013, 1'h1, CMD_WR, 14'h3001},
    '{4'h2, 2'h0, 14'h0000, 1'h1, CMD_PRE, 14'h0000},
    '{4'hb, 2'h1, 14'h1111, 1'h0, CMD_NONE, 14'h0000},
    '{4'h7, 2'h1, 14'h1111, 1'h0, CMD_NONE, 14'h0000},
    '{4'h1, 2'h2, 14'h0000, 1'h0, CMD_NONE, 14'h0000}};
  always #2.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (cmd_valid === 1'h1) pulses++;
  scad_ctrl_model ctrl (.o_ck(ck), .o_cke(cke), .o_cs_n(cs_n), .o_ras_n(ras_n), .o_cas_n(cas_n),
    .o_we_n(we_n), .o_bank(bank), .o_addr(addr), .o_dm(dm), .o_dq(dq_in));
  scad_decode DUT (.i_sys_clk(sys_clk), .i_rst_n(rst_n), .i_ck(ck), .i_cke(cke), .i_cs_n(cs_n),
    .i_ras_n(ras_n), .i_cas_n(cas_n), .i_we_n(we_n), .i_bank_select_inputs(bank),
    .i_multiplexed_address_bus(addr), .i_data_mask_input(dm), .i_dq(dq_in), .i_byte_wide_org(byte_wide),
    .o_dq(dq_out), .o_dq_oe_n(dq_oe_n), .o_dqs(dqs), .o_dqs_oe_n(dqs_oe_n), .o_dqs_c(dqs_c),
    .o_dqs_c_oe_n(dqs_c_oe_n), .o_cmd_valid(cmd_valid), .o_cmd_kind(cmd_kind), .o_cmd_bank(cmd_bank),
    .o_cmd_row(cmd_row), .o_cmd_col(cmd_col), .o_cmd_auto_pre(cmd_ap));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // issue a command and count the record pulses it raises
  task automatic issue(input logic [3:0] ctl, input logic [1:0] b, input logic [13:0] a, input int exp);
    n0 = pulses;
    ctrl.cmd(ctl, b, a);
    repeat (20) @(negedge sys_clk);
    check(pulses - n0, exp);
  endtask
  task automatic wr(input logic [1:0] b, input logic [3:0] c, input logic [31:0] d, input logic [3:0] m);
    ctrl.cmd(4'h4, b, {10'h0, c});
    ctrl.wr_beats(d, m);
    for (int k = 0; k < 4; k++)
      if (!m[k]) shadow[{b, c[3:2], c[1:0] + 2'(k)}] = d[8*k +: 8];
    repeat (2) @(negedge ck);
  endtask
  task automatic rd(input logic [1:0] b, input logic [3:0] c, input logic diff);
    ctrl.cmd(4'h5, b, {10'h0, c});
    // first byte stands after the second link edge past the command
    repeat (2) @(negedge ck);
    for (int k = 0; k < 4; k++) begin
      check({dq_oe_n, dqs_oe_n}, 2'h0);
      check(dq_out, shadow[{b, c[3:2], c[1:0] + 2'(k)}]);
      check(dqs, !k[0]);
      check(dqs_c_oe_n, !diff);
      if (diff) check(dqs_c, k[0]);
      @(negedge ck);
    end
    check({dq_oe_n, dqs_oe_n}, 2'h3);
  endtask
  initial begin
    #100000;
    mismatches++;
    wrap_up();
  end
  initial begin
    // link side needs three of its own edges inside reset
    repeat (6) @(negedge sys_clk);
    repeat (3) @(posedge ck);
    @(negedge sys_clk) rst_n = 1'h1;
    repeat (5) @(negedge ck);
    foreach (rows[i]) begin
      issue(rows[i].ctl, rows[i].bank, rows[i].addr, rows[i].fires);
      if (rows[i].fires) begin
        check(cmd_kind, rows[i].kind);
        check(cmd_bank, rows[i].bank);
        if (rows[i].kind != CMD_PRE) check(cmd_row, rows[i].row);
        if (rows[i].kind inside {CMD_RD, CMD_WR}) check({cmd_ap, cmd_col}, rows[i].addr[10:0]);
      end
    end
    $display("table done");
    issue(4'h3, 2'h2, 14'h0100, 1);
    issue(4'h3, 2'h1, 14'h0200, 1);
    wr(2'h2, 4'h5, 32'h1413_1211, 4'h0);
    wr(2'h2, 4'h5, 32'ha3a2_a1a0, 4'h2);
    wr(2'h1, 4'h5, 32'h5555_5555, 4'h0);
    rd(2'h2, 4'h6, 1'h0);
    $display("store and mask done");
    issue(4'h0, 2'h1, 14'h0000, 1);
    rd(2'h2, 4'h5, 1'h1);
    issue(4'h0, 2'h1, 14'h0400, 1);
    rd(2'h2, 4'h4, 1'h0);
    $display("strobe mode done");
    ctrl.set_cke(1'h0);
    issue(4'h3, 2'h0, 14'h0001, 0);
    ctrl.set_cke(1'h1);
    repeat (3) @(negedge ck);
    ctrl.cmd(4'h5, 2'h2, 14'h0004);
    repeat (3) @(negedge ck);
    ctrl.set_cke(1'h0);
    // gating seen with the third byte: that edge still runs, the next is frozen
    repeat (2) @(negedge ck);
    check({dq_oe_n, dq_out}, {1'h0, shadow[{2'h2, 4'h6}]});
    @(negedge ck);
    check({dq_oe_n, dq_out}, {1'h0, shadow[{2'h2, 4'h6}]});
    ctrl.set_cke(1'h1);
    repeat (10) @(negedge ck);
    check(dq_oe_n, 1'h1);
    $display("clock gating done");
    issue(4'h2, 2'h0, 14'h0400, 1);
    check(cmd_kind, CMD_PRE);
    check(cmd_ap, 1'h0);
    @(negedge sys_clk) byte_wide = 1'h0;
    // strap needs two link edges through its synchroniser
    repeat (3) @(negedge ck);
    issue(4'h3, 2'h1, 14'h3fff, 1);
    check(cmd_row, 14'h1fff);
    @(negedge sys_clk) byte_wide = 1'h1;
    repeat (3) @(negedge ck);
    issue(4'h3, 2'h0, 14'h3fff, 1);
    check(cmd_row, 14'h3fff);
    $display("organisation done");
    @(negedge sys_clk) rst_n = 1'h0;
    repeat (2) @(negedge sys_clk);
    check({dq_oe_n, dqs_oe_n, dqs_c_oe_n, dqs_c, cmd_valid, cmd_kind}, {4'hf, 1'h0, CMD_NONE});
    $display("reset done");
    wrap_up();
  end
endmodule
